//--- design/fsir_pkg.sv
// Constants shared by the FIFO status and interrupt register bank
package fsir_pkg;
	// ---------------------------------------------------------------
	// Widths and counts
	// ---------------------------------------------------------------
	localparam int AW = 4;
	localparam int DW = 8;
	localparam int NCOND = 6;
	localparam int NPORT = 2;
	localparam int NPIN = 3;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] ADR_ISR0 = 4'h0;
	localparam logic [3:0] ADR_ISR1 = 4'h1;
	localparam logic [3:0] ADR_ISR2 = 4'h2;
	localparam logic [3:0] ADR_ISR3 = 4'h3;
	localparam logic [3:0] ADR_CR1 = 4'h4;
	localparam logic [3:0] ADR_CR3 = 4'h5;
	localparam logic [3:0] ADR_MSG = 4'h6;
	localparam logic [3:0] ADR_BUF = 4'h7;
	localparam logic [3:0] ADR_CNT = 4'h8;
	localparam logic [3:0] ADR_CMP = 4'h9;
	localparam logic [3:0] ADR_PAT = 4'hA;
	localparam logic [3:0] ADR_MASK = 4'hB;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int B_IUS_HI = 7;
	localparam int B_IE_HI = 6;
	localparam int B_IP_HI = 5;
	localparam int B_FLAG_HI = 4;
	localparam int B_IUS_LO = 3;
	localparam int B_IE_LO = 2;
	localparam int B_IP_LO = 1;
	localparam int B_FLAG_LO = 0;
	localparam int B_FREEZE = 6;
	localparam int B_OUT_A = 3;
	localparam int B_OUT_B = 1;
	localparam int B_IN = 0;

	// ---------------------------------------------------------------
	// Condition indices and values
	// ---------------------------------------------------------------
	localparam int C_DIR = 0;
	localparam int C_PAT = 1;
	localparam int C_CMP = 2;
	localparam int C_ERR = 3;
	localparam int C_FULL = 4;
	localparam int C_EMPTY = 5;
	localparam logic [7:0] CNT_MAX = 8'h80;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] MASK_RST = 8'h00;
endpackage

//--- design/fsir_regs.sv
// Status, compare, mailbox and interrupt status register bank
// Contract
// - Port 2 I/O pins from control bits 3,1,0
// - Latch every FIFO byte into data buffer
// - Count is writes minus reads, max 80h
// - Freeze bit holds visible count stable
// - Count read completion clears freeze bit
// - Compare holds up to 7Fh, bit7 zero
// - Count equals compare raises compare interrupt
// - Buffer byte matching pattern raises interrupt
// - Masked bits always match; all others agree
// - All-ones mask forces match; reset clears mask
// - Outgoing message appears at other CPU
// - Mailbox status bits 7,6,5; rest zero
// - Incoming message read clears message pending
// - Each condition has enable, pending, in-service
// - Direction and pattern bits at 7-5, 3-1
// - Bit0 shows live match; reset spares pending
// - Count and error bits at 7-5, 3-1
// - Overflow flag bit4 set on full write outside wait mode
// - Underflow flag bit0 set on empty read outside wait mode
// - Full status bits 7-5, reset spares bit0
// - Full pending depends on handshake mode
// - Empty bits 3-1, full flag 4, empty 0
module fsir_regs (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_cs,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_port,
	input wire logic [fsir_pkg::AW-1:0] i_addr,
	input wire logic [fsir_pkg::DW-1:0] i_wdata,
	output logic [fsir_pkg::DW-1:0] o_rdata,
	input wire logic i_fifo_wr,
	input wire logic i_fifo_rd,
	input wire logic [fsir_pkg::DW-1:0] i_fifo_data,
	input wire logic i_wait_sel,
	input wire logic i_dir_change,
	input wire logic i_p2_io,
	input wire logic i_p2_2wire,
	input wire logic i_full_pin,
	input wire logic i_empty_pin,
	input wire logic i_p2_in_pin,
	output logic o_p2_out_a,
	output logic o_p2_out_b,
	output logic o_full,
	output logic o_empty,
	output logic [fsir_pkg::DW-1:0] o_count,
	output logic o_p1_int,
	output logic o_p2_int
);
	import fsir_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [NPIN-1:0] pin_m_q;
	logic [NPIN-1:0] pin_s_q;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] cnt_q;
	logic [7:0] cnt_frz_q;
	logic freeze_q;
	logic inc;
	logic dec;
	logic full;
	logic empty;
	logic [7:0] buf_q;
	logic [7:0] pat_q;
	logic [7:0] mask_q;
	logic [6:0] cmp_q;
	logic latch;
	logic match_now;
	logic pat_hit;
	logic eq;
	logic eq_q;
	logic ovf_q;
	logic udf_q;
	logic ovf_set;
	logic udf_set;
	logic err_clr;
	logic full_flag;
	logic empty_flag;
	logic full_prev_q;
	logic empty_prev_q;
	logic cr3_a_q;
	logic cr3_b_q;
	logic [NCOND-1:0] evt;
	logic [NCOND-1:0] ius_q;
	logic [NCOND-1:0] ie_q;
	logic [NCOND-1:0] ip_q;
	logic [NPORT-1:0] msg_ius_q;
	logic [NPORT-1:0] msg_ie_q;
	logic [NPORT-1:0] msg_ip_q;
	logic [7:0] mb_q [NPORT];
	logic [7:0] rd_d;
	logic [7:0] cr1_v;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Pins come from outside; only the second stage is read
	always_ff @(posedge i_mclk) begin
		pin_m_q <= {i_p2_in_pin, i_empty_pin, i_full_pin};
		pin_s_q <= pin_m_q;
	end

	// Bus strobes; a write takes precedence over a read
	assign wr_acc = i_cs & i_wr;
	assign rd_acc = i_cs & i_rd & ~i_wr;

	// ---------------------------------------------------------------
	// Occupancy count and freeze
	// ---------------------------------------------------------------
	assign full = (cnt_q == CNT_MAX);
	assign empty = (cnt_q == ZERO_BYTE);
	assign inc = i_fifo_wr & ~full;
	assign dec = i_fifo_rd & ~empty;

	// live count, not writable by either CPU
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cnt_q <= ZERO_BYTE;
		end else begin
			cnt_q <= cnt_q + {7'd0, inc} - {7'd0, dec};
		end
	end

	// snapshot tracks live count until frozen
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cnt_frz_q <= ZERO_BYTE;
		end else if (!freeze_q) begin
			cnt_frz_q <= cnt_q;
		end
	end

	// freeze drops once the count read is done
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			freeze_q <= 1'b0;
		end else if (wr_acc && i_addr == ADR_CR1) begin
			freeze_q <= i_wdata[B_FREEZE];
		end else if (rd_acc && i_addr == ADR_CNT) begin
			freeze_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Data buffer and pattern matcher
	// ---------------------------------------------------------------
	assign latch = i_fifo_wr | i_fifo_rd;

	// every byte moved through the RAM is caught
	always_ff @(posedge i_mclk) begin
		if (latch) begin
			buf_q <= i_fifo_data;
		end else if (wr_acc && i_addr == ADR_BUF) begin
			buf_q <= i_wdata;
		end
	end

	// Pattern byte is not reset; its power-up value is unknown
	always_ff @(posedge i_mclk) begin
		if (wr_acc && i_addr == ADR_PAT) begin
			pat_q <= i_wdata;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			mask_q <= MASK_RST;
		end else if (wr_acc && i_addr == ADR_MASK) begin
			mask_q <= i_wdata;
		end
	end

	assign match_now = &(~(buf_q ^ pat_q) | mask_q);
	// test the byte as it enters the buffer
	assign pat_hit = latch & (&(~(i_fifo_data ^ pat_q) | mask_q));

	// ---------------------------------------------------------------
	// Count compare
	// ---------------------------------------------------------------
	// only seven bits are stored
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cmp_q <= 7'd0;
		end else if (wr_acc && i_addr == ADR_CMP) begin
			cmp_q <= i_wdata[6:0];
		end
	end

	// event on entering equality, not while it lasts
	assign eq = (cnt_q == {1'b0, cmp_q});
	// Count and compare both reset to zero, so history starts equal
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			eq_q <= 1'b1;
		end else begin
			eq_q <= eq;
		end
	end

	// ---------------------------------------------------------------
	// Overflow and underflow flags
	// ---------------------------------------------------------------
	// wait mode stalls the CPU, so no overflow there
	assign ovf_set = i_fifo_wr & full & ~i_wait_sel;
	// same for reads from an empty buffer
	assign udf_set = i_fifo_rd & empty & ~i_wait_sel;
	assign err_clr = wr_acc && i_addr == ADR_ISR2 && !i_wdata[B_IP_LO];

	// overflow sticks until error pending clears
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			ovf_q <= 1'b0;
		end else if (ovf_set) begin
			ovf_q <= 1'b1;
		end else if (err_clr) begin
			ovf_q <= 1'b0;
		end
	end

	// underflow cleared with the same command
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			udf_q <= 1'b0;
		end else if (udf_set) begin
			udf_q <= 1'b1;
		end else if (err_clr) begin
			udf_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Full and empty status
	// ---------------------------------------------------------------
	// only 2-wire handshake qualifies full by its pin
	assign full_flag = full & (~i_p2_io | ~i_p2_2wire | pin_s_q[0]);
	// empty is qualified by its pin in I/O mode
	assign empty_flag = empty & (~i_p2_io | pin_s_q[1]);

	// Edge history; empty starts high so reset fires nothing
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			full_prev_q <= 1'b0;
			empty_prev_q <= 1'b1;
		end else begin
			full_prev_q <= full_flag;
			empty_prev_q <= empty_flag;
		end
	end

	// Hardware events per condition
	assign evt[C_DIR] = i_dir_change;
	assign evt[C_PAT] = pat_hit;
	assign evt[C_CMP] = eq & ~eq_q;
	assign evt[C_ERR] = ovf_set | udf_set;
	assign evt[C_FULL] = full_flag & ~full_prev_q;
	assign evt[C_EMPTY] = empty_flag & ~empty_prev_q;

	// ---------------------------------------------------------------
	// Interrupt status bits
	// ---------------------------------------------------------------
	// three bits per condition, pending set wins
	for (genvar g = 0; g < NCOND; g++) begin : g_cond
		localparam logic [3:0] A = ADR_ISR1 + 4'(g / 2);
		localparam int BS = (g % 2 == 0) ? B_IUS_HI : B_IUS_LO;
		localparam int BE = (g % 2 == 0) ? B_IE_HI : B_IE_LO;
		localparam int BP = (g % 2 == 0) ? B_IP_HI : B_IP_LO;
		logic w;
		assign w = wr_acc && i_addr == A;
		always_ff @(posedge i_mclk) begin
			if (i_srst) begin
				ius_q[g] <= 1'b0;
				ie_q[g] <= 1'b0;
				if (g != C_PAT) begin
					ip_q[g] <= 1'b0;
				end
			end else begin
				if (w) begin
					ius_q[g] <= i_wdata[BS];
					ie_q[g] <= i_wdata[BE];
				end
				if (evt[g]) begin
					ip_q[g] <= 1'b1;
				end else if (w) begin
					ip_q[g] <= i_wdata[BP];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Mailbox, one incoming register per port
	// ---------------------------------------------------------------
	for (genvar q = 0; q < NPORT; q++) begin : g_port
		logic own;
		logic msg_in;
		logic msg_rd;
		logic isr_w;
		assign own = (i_port == 1'(q));
		assign msg_in = wr_acc && i_addr == ADR_MSG && !own;
		assign msg_rd = rd_acc && i_addr == ADR_MSG && own;
		assign isr_w = wr_acc && i_addr == ADR_ISR0 && own;

		// the other CPU's write lands here
		always_ff @(posedge i_mclk) begin
			if (msg_in) begin
				mb_q[q] <= i_wdata;
			end
		end

		always_ff @(posedge i_mclk) begin
			if (i_srst) begin
				msg_ius_q[q] <= 1'b0;
				msg_ie_q[q] <= 1'b0;
				msg_ip_q[q] <= 1'b0;
			end else begin
				if (isr_w) begin
					msg_ius_q[q] <= i_wdata[B_IUS_HI];
					msg_ie_q[q] <= i_wdata[B_IE_HI];
				end
				if (msg_in) begin
					msg_ip_q[q] <= 1'b1;
				end else if (msg_rd || isr_w) begin
					msg_ip_q[q] <= isr_w & i_wdata[B_IP_HI];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Port 2 simple I/O bits
	// ---------------------------------------------------------------
	// only the port 1 CPU owns these bits
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cr3_a_q <= 1'b0;
			cr3_b_q <= 1'b0;
		end else if (wr_acc && !i_port && i_addr == ADR_CR3) begin
			cr3_a_q <= i_wdata[B_OUT_A];
			cr3_b_q <= i_wdata[B_OUT_B];
		end
	end

	// pins driven only in I/O mode
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_p2_out_a <= 1'b0;
			o_p2_out_b <= 1'b0;
		end else begin
			o_p2_out_a <= cr3_a_q & i_p2_io;
			o_p2_out_b <= cr3_b_q & i_p2_io;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Read data mux; unmapped offsets return zero
	always_comb begin
		cr1_v = ZERO_BYTE;
		cr1_v[B_FREEZE] = freeze_q;
		rd_d = ZERO_BYTE;
		unique case (i_addr)
			ADR_ISR0: rd_d = {msg_ius_q[i_port], msg_ie_q[i_port],
				msg_ip_q[i_port], 5'd0};
			// bit 0 is the live match
			ADR_ISR1: rd_d = {ius_q[C_DIR], ie_q[C_DIR], ip_q[C_DIR],
				1'b0, ius_q[C_PAT], ie_q[C_PAT], ip_q[C_PAT],
				match_now};
			// count and error groups with error flags
			ADR_ISR2: rd_d = {ius_q[C_CMP], ie_q[C_CMP], ip_q[C_CMP],
				ovf_q, ius_q[C_ERR], ie_q[C_ERR], ip_q[C_ERR], udf_q};
			// full group high, empty group low
			ADR_ISR3: rd_d = {ius_q[C_FULL], ie_q[C_FULL],
				ip_q[C_FULL], full_flag, ius_q[C_EMPTY],
				ie_q[C_EMPTY], ip_q[C_EMPTY], empty_flag};
			ADR_CR1: rd_d = cr1_v;
			// port 2 CPU sees zeros here
			ADR_CR3: rd_d = i_port ? ZERO_BYTE : {4'd0, cr3_a_q, 1'b0,
				cr3_b_q, pin_s_q[2] & i_p2_io};
			ADR_MSG: rd_d = mb_q[i_port];
			ADR_BUF: rd_d = buf_q;
			// frozen snapshot shown while freeze is set
			ADR_CNT: rd_d = freeze_q ? cnt_frz_q : cnt_q;
			ADR_CMP: rd_d = {1'b0, cmp_q};
			ADR_PAT: rd_d = pat_q;
			ADR_MASK: rd_d = mask_q;
			default: rd_d = ZERO_BYTE;
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rdata <= ZERO_BYTE;
		end else if (rd_acc) begin
			o_rdata <= rd_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_full = full;
	assign o_empty = empty;

	// Requests: enabled, pending and not already in service
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_count <= ZERO_BYTE;
			o_p1_int <= 1'b0;
			o_p2_int <= 1'b0;
		end else begin
			o_count <= cnt_q;
			o_p1_int <= (|(ie_q & ip_q & ~ius_q)) |
				(msg_ie_q[0] & msg_ip_q[0] & ~msg_ius_q[0]);
			o_p2_int <= msg_ie_q[1] & msg_ip_q[1] & ~msg_ius_q[1];
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	// count bound
	a_count_bound: assert property (@(posedge i_mclk) disable iff (i_srst)
		cnt_q <= CNT_MAX) else $error("count above limit");
	a_freeze_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
		freeze_q |=> $stable(cnt_frz_q)) else $error("frozen moved");
	a_freeze_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
		rd_acc && i_addr == ADR_CNT |=> !freeze_q)
		else $error("freeze stuck");
	a_cmp_top: assert property (@(posedge i_mclk) disable iff (i_srst)
		rd_acc && i_addr == ADR_CMP |=> !o_rdata[7])
		else $error("compare bit 7 set");
	a_cmp_pend: assert property (@(posedge i_mclk) disable iff (i_srst)
		eq && !$past(eq) |=> ip_q[C_CMP]) else $error("no compare ip");
	a_pat_pend: assert property (@(posedge i_mclk) disable iff (i_srst)
		pat_hit |=> ip_q[C_PAT] && match_now)
		else $error("no pattern ip");
	a_mask_ones: assert property (@(posedge i_mclk) disable iff (i_srst)
		mask_q == ALL_ONES |-> match_now) else $error("mask no match");
	a_buf_latch: assert property (@(posedge i_mclk) disable iff (i_srst)
		latch |=> buf_q == $past(i_fifo_data))
		else $error("byte not latched");
	a_mbox_deliv: assert property (@(posedge i_mclk) disable iff (i_srst)
		wr_acc && i_addr == ADR_MSG && !i_port |=> mb_q[1] ==
		$past(i_wdata) && msg_ip_q[1]) else $error("message lost");
	a_mbox_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
		rd_acc && i_addr == ADR_MSG && i_port |=> !msg_ip_q[1])
		else $error("message ip stuck");
	a_ovf_flag: assert property (@(posedge i_mclk) disable iff (i_srst)
		ovf_set |=> ovf_q && ip_q[C_ERR]) else $error("no overflow");
	a_udf_flag: assert property (@(posedge i_mclk) disable iff (i_srst)
		udf_set |=> udf_q && ip_q[C_ERR]) else $error("no underflow");
endmodule

//--- testbench/fsir_host_model.sv
// Host CPU and FIFO RAM side model driving the register bank
module fsir_host_model (
	input wire logic i_mclk,
	input wire logic [fsir_pkg::DW-1:0] i_rdata,
	output logic o_cs,
	output logic o_wr,
	output logic o_rd,
	output logic o_port,
	output logic [fsir_pkg::AW-1:0] o_addr,
	output logic [fsir_pkg::DW-1:0] o_wdata,
	output logic o_fifo_wr,
	output logic o_fifo_rd,
	output logic [fsir_pkg::DW-1:0] o_fifo_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import fsir_pkg::*;

	// Idle bus at time zero
	initial begin
		{o_cs, o_wr, o_rd, o_port, o_fifo_wr, o_fifo_rd} = '0;
		o_addr = '0;
		o_wdata = '0;
		o_fifo_data = '0;
	end

	// Register write, one strobe cycle, data inverted once released
	task automatic bus_wr(input logic p, input logic [3:0] a,
		input logic [7:0] d);
		@(negedge i_mclk);
		{o_cs, o_wr, o_port, o_addr, o_wdata} = {2'b11, p, a, d};
		@(negedge i_mclk);
		{o_cs, o_wr, o_wdata} = {2'b00, ~d};
	endtask

	// Register read, data taken one cycle after the strobe
	task automatic bus_rd(input logic p, input logic [3:0] a,
		output logic [7:0] d);
		@(negedge i_mclk);
		{o_cs, o_rd, o_port, o_addr} = {2'b11, p, a};
		@(negedge i_mclk);
		d = i_rdata;
		{o_cs, o_rd} = 2'b00;
	endtask

	// One byte moved into or out of the RAM
	task automatic fifo_op(input logic is_wr, input logic [7:0] d);
		@(negedge i_mclk);
		{o_fifo_wr, o_fifo_rd, o_fifo_data} = {is_wr, ~is_wr, d};
		@(negedge i_mclk);
		{o_fifo_wr, o_fifo_rd, o_fifo_data} = {2'b00, ~d};
	endtask
endmodule

//--- testbench/fsir_regs_tb.sv
// Self-checking bench for the status and interrupt register bank
module fsir_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fsir_pkg::*;

	logic i_mclk, i_srst, cs, wr_s, rd_s, port, fwr, frd;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata, fdata, count;
	logic wait_sel, dir_chg, p2_io, two_wire, full_pin, empty_pin, in_pin;
	logic out_a, out_b, full, empty, p1_int, p2_int;
	int fail_count, cmp_count;

	fsir_regs u_fsir_regs (.i_mclk(i_mclk), .i_srst(i_srst), .i_cs(cs),
		.i_wr(wr_s), .i_rd(rd_s), .i_port(port), .i_addr(addr),
		.i_wdata(wdata), .o_rdata(rdata), .i_fifo_wr(fwr),
		.i_fifo_rd(frd), .i_fifo_data(fdata), .i_wait_sel(wait_sel),
		.i_dir_change(dir_chg), .i_p2_io(p2_io), .i_p2_2wire(two_wire),
		.i_full_pin(full_pin), .i_empty_pin(empty_pin),
		.i_p2_in_pin(in_pin), .o_p2_out_a(out_a), .o_p2_out_b(out_b),
		.o_full(full), .o_empty(empty), .o_count(count),
		.o_p1_int(p1_int), .o_p2_int(p2_int));

	fsir_host_model u_fsir_host_model (.i_mclk(i_mclk), .i_rdata(rdata),
		.o_cs(cs), .o_wr(wr_s), .o_rd(rd_s), .o_port(port),
		.o_addr(addr), .o_wdata(wdata), .o_fifo_wr(fwr),
		.o_fifo_rd(frd), .o_fifo_data(fdata));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic wrap_up;
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic p, input logic [3:0] a,
		input logic [7:0] d);
		u_fsir_host_model.bus_wr(p, a, d);
	endtask

	task automatic chk_rd(input logic p, input logic [3:0] a,
		input logic [7:0] exp, input string what);
		logic [7:0] d;
		u_fsir_host_model.bus_rd(p, a, d);
		check(what, d, exp);
	endtask

	task automatic push(input logic [7:0] d);
		u_fsir_host_model.fifo_op(1'b1, d);
	endtask

	task automatic pop(input logic [7:0] d);
		u_fsir_host_model.fifo_op(1'b0, d);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// reset values
	task automatic t_reset;
		chk_rd(0, ADR_ISR0, 8'h00, "isr0 reset");
		chk_rd(0, ADR_ISR2, 8'h00, "isr2 reset");
		chk_rd(0, ADR_ISR3, 8'h01, "isr3 reset");
		chk_rd(0, ADR_MASK, 8'h00, "mask reset");
		chk_rd(0, ADR_CNT, 8'h00, "count reset");
	endtask

	task automatic t_bits;
		wr(0, ADR_ISR0, 8'hFF);
		chk_rd(0, ADR_ISR0, 8'hE0, "isr0 unused");
		wr(0, ADR_ISR0, 8'h00);
		wr(0, ADR_ISR2, 8'hEE);
		chk_rd(0, ADR_ISR2, 8'hEE, "isr2 bits");
		wr(0, ADR_ISR2, 8'h00);
		// Known match flag before touching the pattern bits
		wr(0, ADR_MASK, 8'hFF);
		wr(0, ADR_ISR1, 8'hFE);
		chk_rd(0, ADR_ISR1, 8'hEF, "isr1 bits");
		wr(0, ADR_ISR1, 8'h00);
		@(negedge i_mclk) dir_chg = 1'b1;
		@(negedge i_mclk) dir_chg = 1'b0;
		chk_rd(0, ADR_ISR1, 8'h21, "dir pending");
		wr(0, ADR_ISR1, 8'h00);
	endtask

	task automatic t_compare;
		wr(0, ADR_CMP, 8'hFF);
		chk_rd(0, ADR_CMP, 8'h7F, "cmp top bit");
		wr(0, ADR_CMP, 8'h02);
		wr(0, ADR_ISR2, 8'h40);
		push(8'h11);
		chk_rd(0, ADR_ISR2, 8'h40, "cmp early");
		push(8'h22);
		chk_rd(0, ADR_ISR2, 8'h60, "cmp hit");
		check("p1 int cmp", {7'h0, p1_int}, 8'h01);
		chk_rd(0, ADR_BUF, 8'h22, "buf write");
		check("count two", count, 8'h02);
		pop(8'h11);
		chk_rd(0, ADR_BUF, 8'h11, "buf read");
		pop(8'h22);
		wr(0, ADR_ISR2, 8'h00);
	endtask

	task automatic t_pattern;
		wr(0, ADR_ISR1, 8'h00);
		wr(0, ADR_ISR1, 8'h04);
		wr(0, ADR_PAT, 8'hA5);
		wr(0, ADR_MASK, 8'h0F);
		push(8'hA3);
		chk_rd(0, ADR_ISR1, 8'h07, "pat hit");
		check("p1 int pat", {7'h0, p1_int}, 8'h01);
		push(8'h53);
		chk_rd(0, ADR_ISR1, 8'h06, "pat miss");
		wr(0, ADR_MASK, 8'hFF);
		chk_rd(0, ADR_ISR1, 8'h07, "pat forced");
		pop(8'hA3);
		pop(8'h53);
		wr(0, ADR_ISR1, 8'h00);
	endtask

	task automatic t_freeze;
		push(8'h01);
		wr(0, ADR_CR1, 8'h40);
		push(8'h02);
		// Count output is a registered copy, one cycle behind
		@(negedge i_mclk);
		check("live count", count, 8'h02);
		chk_rd(0, ADR_CNT, 8'h01, "frozen count");
		chk_rd(0, ADR_CR1, 8'h00, "freeze clear");
		chk_rd(0, ADR_CNT, 8'h02, "thawed count");
		pop(8'h01);
		pop(8'h02);
	endtask

	task automatic t_fill;
		// Fill in 2-wire I/O mode with the full pin low
		{p2_io, two_wire} = 2'b11;
		for (int i = 0; i < 128; i++)
			push(8'(i));
		check("full flag", {7'h0, full}, 8'h01);
		wr(0, ADR_ISR3, 8'h00);
		chk_rd(0, ADR_ISR3, 8'h00, "full pin low");
		full_pin = 1'b1;
		repeat (3) @(negedge i_mclk);
		chk_rd(0, ADR_ISR3, 8'h30, "full pin high");
		{p2_io, two_wire, full_pin} = 3'b000;
		wr(0, ADR_ISR2, 8'h00);
		push(8'hEE);
		chk_rd(0, ADR_CNT, 8'h80, "count cap");
		chk_rd(0, ADR_ISR2, 8'h12, "overflow");
		wr(0, ADR_ISR2, 8'h00);
		chk_rd(0, ADR_ISR2, 8'h00, "ovf cleared");
		for (int i = 0; i < 128; i++)
			pop(8'(i));
		check("empty flag", {7'h0, empty}, 8'h01);
		wr(0, ADR_ISR2, 8'h00);
		pop(8'h33);
		chk_rd(0, ADR_ISR2, 8'h03, "underflow");
		wr(0, ADR_ISR2, 8'h00);
		wait_sel = 1'b1;
		pop(8'h44);
		chk_rd(0, ADR_ISR2, 8'h00, "wait no udf");
		wait_sel = 1'b0;
	endtask

	task automatic t_mail;
		wr(1, ADR_ISR0, 8'h40);
		wr(0, ADR_MSG, 8'h5A);
		chk_rd(1, ADR_ISR0, 8'h60, "msg pending");
		check("p2 int on", {7'h0, p2_int}, 8'h01);
		chk_rd(1, ADR_MSG, 8'h5A, "msg data");
		chk_rd(1, ADR_ISR0, 8'h40, "msg read clr");
		check("p2 int off", {7'h0, p2_int}, 8'h00);
	endtask

	task automatic t_pins;
		p2_io = 1'b1;
		wr(0, ADR_CR3, 8'h0A);
		// Output pins follow the control bits one cycle later
		@(negedge i_mclk);
		check("out pins", {6'h0, out_a, out_b}, 8'h03);
		in_pin = 1'b1;
		repeat (4) @(negedge i_mclk);
		chk_rd(0, ADR_CR3, 8'h0B, "in pin");
		chk_rd(1, ADR_CR3, 8'h00, "cr3 port2");
		p2_io = 1'b0;
		repeat (2) @(negedge i_mclk);
		chk_rd(0, ADR_CR3, 8'h0A, "cr3 no io");
		check("pins idle", {6'h0, out_a, out_b}, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	// Main sequence; inputs change on falling edges only
	initial begin
		fail_count = 0;
		cmp_count = 0;
		{wait_sel, dir_chg, p2_io, two_wire, full_pin, in_pin} = '0;
		empty_pin = 1'b1;
		i_srst = 1'b1;
		repeat (2) @(negedge i_mclk);
		i_srst = 1'b0;
		t_reset();
		t_bits();
		t_compare();
		t_pattern();
		t_freeze();
		t_fill();
		t_mail();
		t_pins();
		wrap_up();
	end

	// Hang guard, well beyond the roughly 680 cycles used
	initial begin
		repeat (20000) @(posedge i_mclk);
		fail_count++;
		wrap_up();
	end
endmodule
